// ==== hw_break_and_trace_unit.sv ====
`timescale 1ns/10ps
module hw_break_and_trace_unit
  import hw_break_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic [hw_break_pkg::ADDR_W-1:0] busAddr,
  input wire logic [hw_break_pkg::DATA_W-1:0] busData,
  input wire logic [2:0] busState,
  input wire logic busWrite,
  input wire logic busValid,
  input wire logic progRunning,
  input wire logic [hw_break_pkg::NUM_EXC-1:0] excEvent,
  output logic haltReq,
  output logic breakArmed
);
  import hw_break_pkg::*;

  localparam int REC_W = 3 + 1 + ADDR_W + DATA_W;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    cfg_s shadow;
    cfg_s active;
    logic [NUM_DET-1:0] accLatch;
    logic [2:0] seqStep;
    ts_state_e tsState;
    logic [ADDR_W-1:0] pc;
    logic [DELAY_W-1:0] delayCnt;
    logic delayRun;
    logic armed;
    logic haltReq;
    logic runPrev;
    logic [TRACE_AW-1:0] wrPtr;
    logic wrapped;
    logic stopSeen;
    logic [DELAY_W:0] afterStop;
    logic [TRACE_AW-1:0] trIdx;
    logic [31:0] rdata;
  } unit_s;

  unit_s s;
  unit_s next_s;

  logic [NUM_DET-1:0] hit;
  logic [REC_W-1:0] traceMem [TRACE_DEPTH];
  logic [REC_W-1:0] traceOut;
  logic traceWe;
  logic [TRACE_AW-1:0] writeAddr;
  logic [TRACE_AW-1:0] readAddr;
  logic [REC_W-1:0] record;

  // ****************************************************************
  // Event detectors
  // ****************************************************************
  for (genvar i = 0; i < NUM_DET; i++) begin : g_det
    event_detector u_det (
      .clock(clock),
      .rst(rst),
      .cfgAddr(s.active.detAddr[i]),
      .cfgMask(s.active.detMask[i]),
      .cfgCtrl(s.active.detCtrl[i]),
      .busAddr(busAddr),
      .busState(busState),
      .busWrite(busWrite),
      .busValid(busValid),
      .hit(hit[i])
    );
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic orHit;
    logic altHit;
    logic excHit;
    logic breakHit;
    logic apply;
    logic runStart;
    logic pathTaken;
    logic [NUM_DET-1:0] andSel;
    logic [NUM_DET-1:0] accNext;
    logic [2:0] seqLast;
    logic [3:0] detIdx;
    logic [TRACE_AW-1:0] ptrBase;
    next_s = s;
    next_s.haltReq = 1'b0;
    next_s.rdata = '0;
    orHit = 1'b0;
    altHit = 1'b0;
    excHit = 1'b0;
    pathTaken = 1'b0;
    breakHit = 1'b0;
    ptrBase = '0;
    apply = regWrite && (regAddr == REG_APPLY);
    runStart = progRunning && !s.runPrev;
    andSel = hit & s.active.andMask;
    accNext = s.accLatch | andSel;
    detIdx = regAddr[4:1];
    seqLast = (s.active.seqLen == '0 || s.active.seqLen > SEQ_LEN_MAX) ?
              SEQ_LEN_MAX - 3'h1 : s.active.seqLen - 3'h1;
    next_s.runPrev = progRunning;

    // Register writes land in the shadow copy, except the trace index, which takes effect at once
    if (regWrite) begin
      case (regAddr)
        REG_CTRL: begin
          next_s.shadow.orEn = regWdata[CTRL_OR_BIT];
          next_s.shadow.altEn = regWdata[CTRL_ALT_BIT];
          next_s.shadow.altMode = alt_mode_e'(regWdata[CTRL_MODE_LSB +: 3]);
        end
        REG_OR_MASK: next_s.shadow.orMask = regWdata[NUM_DET-1:0];
        REG_AND_MASK: next_s.shadow.andMask = regWdata[NUM_DET-1:0];
        REG_EXC_MASK: next_s.shadow.excMask = regWdata[NUM_EXC-1:0];
        REG_DELAY: next_s.shadow.delay = regWdata[DELAY_W-1:0];
        REG_RANGE_LO: next_s.shadow.rangeLo = regWdata[ADDR_W-1:0];
        REG_RANGE_HI: next_s.shadow.rangeHi = regWdata[ADDR_W-1:0];
        REG_SUBR_EVT: next_s.shadow.subrEvt = regWdata[EVT_W-1:0];
        REG_SEQ: begin
          next_s.shadow.seqEvt = regWdata[SEQ_STEPS*EVT_W-1:0];
          next_s.shadow.seqLen = regWdata[SEQ_LEN_LSB +: 3];
        end
        REG_SEQ_RST: next_s.shadow.seqRst = regWdata[EVT_W:0];
        REG_TS_RST: next_s.shadow.tsRst = regWdata[EVT_W:0];
        REG_TRACE_IDX: next_s.trIdx = regWdata[TRACE_AW-1:0];
        default: begin
          if (regAddr >= REG_PATH_BASE && regAddr < REG_PATH_BASE + 8'(TS_PATHS)) begin
            next_s.shadow.tsPath[4'(regAddr - REG_PATH_BASE)] = regWdata[PATH_W-1:0];
          end
          if (regAddr[7:5] == REG_DET_BASE[7:5]) begin
            if (regAddr[0]) begin
              next_s.shadow.detMask[detIdx] = regWdata[ADDR_W-1:0];
            end else begin
              next_s.shadow.detAddr[detIdx] = regWdata[ADDR_W-1:0];
              next_s.shadow.detCtrl[detIdx] = regWdata[DET_CTRL_LSB +: DET_CTRL_W];
            end
          end
        end
      endcase
    end

    // Last instruction fetch address stands for the execution point
    if (busValid && (busState == BIU_INSTR_BYTE_FETCH || busState == BIU_INSTR_WORD_FETCH)) begin
      next_s.pc = busAddr;
    end

    // Combiners
    orHit = s.active.orEn && |(hit & s.active.orMask);
    excHit = |(excEvent & s.active.excMask);
    if (s.active.altEn) begin
      case (s.active.altMode)
        MODE_AND_ACC: begin
          next_s.accLatch = accNext;
          if (s.active.andMask != '0 && accNext == s.active.andMask) begin
            altHit = 1'b1;
            next_s.accLatch = '0;
          end
        end
        MODE_AND_SIM: begin
          altHit = s.active.andMask != '0 && andSel == s.active.andMask;
        end
        MODE_SUBR: begin
          altHit = hit[s.active.subrEvt] && s.pc >= s.active.rangeLo &&
                   s.pc <= s.active.rangeHi;
        end
        MODE_SEQ: begin
          // Reset point wins over a step event in the same cycle
          if (s.active.seqRst[RST_EN_BIT] && hit[s.active.seqRst[EVT_W-1:0]]) begin
            next_s.seqStep = '0;
          end else if (hit[s.active.seqEvt[s.seqStep]]) begin
            if (s.seqStep >= seqLast) begin
              altHit = 1'b1;
              next_s.seqStep = '0;
            end else begin
              next_s.seqStep = s.seqStep + 3'h1;
            end
          end
        end
        MODE_STATE: begin
          if (s.active.tsRst[RST_EN_BIT] && hit[s.active.tsRst[EVT_W-1:0]]) begin
            next_s.tsState = TS_S0;
          end else begin
            // Lowest numbered matching path wins
            for (int p = 0; p < TS_PATHS; p++) begin
              if (!pathTaken && s.active.tsPath[p][PATH_EN_BIT] &&
                  s.active.tsPath[p][PATH_FROM_LSB +: 2] == s.tsState &&
                  hit[s.active.tsPath[p][PATH_EVT_LSB +: EVT_W]]) begin
                pathTaken = 1'b1;
                if (s.active.tsPath[p][PATH_TO_LSB +: 2] == TS_BREAK) begin
                  altHit = 1'b1;
                  next_s.tsState = TS_S0;
                end else begin
                  next_s.tsState = ts_state_e'(s.active.tsPath[p][PATH_TO_LSB +: 2]);
                end
              end
            end
          end
        end
        default: altHit = 1'b0;
      endcase
    end
    breakHit = orHit || altHit || excHit;

    // Break delay and halt request
    if (apply || runStart) begin
      next_s.armed = 1'b1;
      next_s.delayRun = 1'b0;
      next_s.delayCnt = DELAY_RST;
    end else if (s.armed) begin
      if (s.delayRun) begin
        if (s.delayCnt == DELAY_ONE) begin
          next_s.haltReq = 1'b1;
          next_s.armed = 1'b0;
          next_s.delayRun = 1'b0;
        end else begin
          next_s.delayCnt = s.delayCnt - DELAY_ONE;
        end
      end else if (breakHit) begin
        next_s.stopSeen = 1'b1;
        next_s.afterStop = '0;
        if (s.active.delay == DELAY_RST) begin
          next_s.haltReq = 1'b1;
          next_s.armed = 1'b0;
        end else begin
          next_s.delayRun = 1'b1;
          next_s.delayCnt = s.active.delay;
        end
      end
    end

    // New settings go live together; combiner history restarts
    if (apply) begin
      next_s.active = s.shadow;
      next_s.accLatch = '0;
      next_s.seqStep = '0;
      next_s.tsState = TS_S0;
    end

    // Trace pointer: continuous fill, wraps over the oldest record
    ptrBase = runStart ? '0 : s.wrPtr;
    if (runStart) begin
      next_s.wrapped = 1'b0;
      next_s.stopSeen = 1'b0;
      next_s.afterStop = '0;
    end
    if (progRunning) begin
      next_s.wrPtr = ptrBase + 1'b1;
      if (ptrBase == '1) begin
        next_s.wrapped = 1'b1;
      end
      if (s.stopSeen && !(s.armed && !s.delayRun && breakHit) && s.afterStop != '1) begin
        next_s.afterStop = s.afterStop + 1'b1;
      end
    end

    // Register reads, answered in the following cycle
    if (regRead) begin
      case (regAddr)
        REG_CTRL: begin
          next_s.rdata[CTRL_OR_BIT] = s.shadow.orEn;
          next_s.rdata[CTRL_ALT_BIT] = s.shadow.altEn;
          next_s.rdata[CTRL_MODE_LSB +: 3] = s.shadow.altMode;
        end
        REG_OR_MASK: next_s.rdata[NUM_DET-1:0] = s.shadow.orMask;
        REG_AND_MASK: next_s.rdata[NUM_DET-1:0] = s.shadow.andMask;
        REG_EXC_MASK: next_s.rdata[NUM_EXC-1:0] = s.shadow.excMask;
        REG_DELAY: next_s.rdata[DELAY_W-1:0] = s.shadow.delay;
        REG_RANGE_LO: next_s.rdata[ADDR_W-1:0] = s.shadow.rangeLo;
        REG_RANGE_HI: next_s.rdata[ADDR_W-1:0] = s.shadow.rangeHi;
        REG_SUBR_EVT: next_s.rdata[EVT_W-1:0] = s.shadow.subrEvt;
        REG_SEQ: begin
          next_s.rdata[SEQ_STEPS*EVT_W-1:0] = s.shadow.seqEvt;
          next_s.rdata[SEQ_LEN_LSB +: 3] = s.shadow.seqLen;
        end
        REG_SEQ_RST: next_s.rdata[EVT_W:0] = s.shadow.seqRst;
        REG_TS_RST: next_s.rdata[EVT_W:0] = s.shadow.tsRst;
        REG_STATUS: begin
          next_s.rdata[ST_ARMED_BIT] = s.armed;
          next_s.rdata[ST_DELAY_BIT] = s.delayRun;
          next_s.rdata[ST_WRAP_BIT] = s.wrapped;
          next_s.rdata[ST_STOP_BIT] = s.stopSeen;
          next_s.rdata[ST_SEQ_LSB +: 3] = s.seqStep;
          next_s.rdata[ST_TS_LSB +: 2] = s.tsState;
        end
        REG_TRACE_PTR: begin
          next_s.rdata[TRACE_AW-1:0] = s.wrPtr;
          next_s.rdata[PTR_WRAP_BIT] = s.wrapped;
        end
        REG_TRACE_IDX: next_s.rdata[TRACE_AW-1:0] = s.trIdx;
        REG_TRACE_REC: next_s.rdata = 32'(traceOut[REC_W-1:DATA_W]);
        REG_TRACE_DATA: next_s.rdata[DATA_W-1:0] = traceOut[DATA_W-1:0];
        REG_STOP_NUM: next_s.rdata[DELAY_W:0] = s.afterStop;
        default: begin
          if (regAddr >= REG_PATH_BASE && regAddr < REG_PATH_BASE + 8'(TS_PATHS)) begin
            next_s.rdata[PATH_W-1:0] = s.shadow.tsPath[4'(regAddr - REG_PATH_BASE)];
          end
          if (regAddr[7:5] == REG_DET_BASE[7:5]) begin
            if (regAddr[0]) begin
              next_s.rdata[ADDR_W-1:0] = s.shadow.detMask[detIdx];
            end else begin
              next_s.rdata[ADDR_W-1:0] = s.shadow.detAddr[detIdx];
              next_s.rdata[DET_CTRL_LSB +: DET_CTRL_W] = s.shadow.detCtrl[detIdx];
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.shadow.orEn <= 1'b1;
      s.active.orEn <= 1'b1;
      s.shadow.altMode <= MODE_AND_ACC;
      s.active.altMode <= MODE_AND_ACC;
      s.shadow.delay <= DELAY_RST;
      s.active.delay <= DELAY_RST;
      s.tsState <= TS_S0;
      s.armed <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Trace memory
  // ****************************************************************
  // Writes only while running, so a halt leaves the contents frozen
  assign traceWe = progRunning;
  assign writeAddr = (progRunning && !s.runPrev) ? '0 : s.wrPtr;
  assign readAddr = s.wrPtr - 1'b1 - s.trIdx;
  assign record = {busState, busWrite, busAddr, busData};

  // Plain array so synthesis can map it onto block memory; no reset
  always_ff @(posedge clock) begin
    if (traceWe) begin
      traceMem[writeAddr] <= record;
    end
    traceOut <= traceMem[readAddr];
  end

  assign regRdata = s.rdata;
  assign haltReq = s.haltReq;
  assign breakArmed = s.armed;

endmodule

// ==== hw_break_pkg.sv ====
package hw_break_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_DET = 16;
  localparam int NUM_EXC = 7;
  localparam int SEQ_STEPS = 6;
  localparam int TS_PATHS = 9;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int EVT_W = 4;
  localparam int DELAY_W = 16;
  localparam int TRACE_AW = 22;
  localparam int TRACE_DEPTH = 1 << TRACE_AW;
  localparam int DET_CTRL_W = 7;
  localparam int PATH_W = 9;

  // ****************************************************************
  // Register map (word addresses on regAddr)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OR_MASK = 8'h01;
  localparam logic [7:0] REG_AND_MASK = 8'h02;
  localparam logic [7:0] REG_EXC_MASK = 8'h03;
  localparam logic [7:0] REG_DELAY = 8'h04;
  localparam logic [7:0] REG_RANGE_LO = 8'h05;
  localparam logic [7:0] REG_RANGE_HI = 8'h06;
  localparam logic [7:0] REG_SUBR_EVT = 8'h07;
  localparam logic [7:0] REG_SEQ = 8'h08;
  localparam logic [7:0] REG_SEQ_RST = 8'h09;
  localparam logic [7:0] REG_TS_RST = 8'h0a;
  localparam logic [7:0] REG_APPLY = 8'h0b;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_TRACE_PTR = 8'h0d;
  localparam logic [7:0] REG_TRACE_IDX = 8'h0e;
  localparam logic [7:0] REG_TRACE_REC = 8'h0f;
  localparam logic [7:0] REG_TRACE_DATA = 8'h10;
  localparam logic [7:0] REG_STOP_NUM = 8'h11;
  localparam logic [7:0] REG_PATH_BASE = 8'h17;
  localparam logic [7:0] REG_DET_BASE = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_OR_BIT = 0;
  localparam int CTRL_ALT_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int SEQ_LEN_LSB = 24;
  localparam int RST_EN_BIT = 4;
  localparam int DET_CTRL_LSB = 24;
  localparam int DCTL_EN_BIT = 0;
  localparam int DCTL_RW_LSB = 1;
  localparam int DCTL_ANY_BIT = 3;
  localparam int DCTL_STATE_LSB = 4;
  localparam int PATH_EVT_LSB = 0;
  localparam int PATH_TO_LSB = 4;
  localparam int PATH_FROM_LSB = 6;
  localparam int PATH_EN_BIT = 8;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_DELAY_BIT = 1;
  localparam int ST_WRAP_BIT = 2;
  localparam int ST_STOP_BIT = 3;
  localparam int ST_SEQ_LSB = 4;
  localparam int ST_TS_LSB = 8;
  localparam int PTR_WRAP_BIT = 31;

  // ****************************************************************
  // Reset and special values
  // ****************************************************************
  localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
  localparam logic [DELAY_W-1:0] DELAY_ONE = 16'h0001;
  localparam logic [2:0] SEQ_LEN_MAX = 3'h6;
  localparam logic [1:0] RW_ANY = 2'h0;
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h2;

  typedef enum logic [2:0] {
    MODE_AND_ACC = 3'b000,
    MODE_AND_SIM = 3'b001,
    MODE_SUBR = 3'b010,
    MODE_SEQ = 3'b011,
    MODE_STATE = 3'b100
  } alt_mode_e;

  typedef enum logic [1:0] {
    TS_S0 = 2'b00,
    TS_S1 = 2'b01,
    TS_S2 = 2'b10,
    TS_BREAK = 2'b11
  } ts_state_e;

  typedef enum logic [2:0] {
    BIU_IDLE = 3'b000,
    BIU_NON_CPU = 3'b001,
    BIU_INT_ACK = 3'b010,
    BIU_INSTR_BYTE_FETCH = 3'b011,
    BIU_DATA_BYTE_ACCESS = 3'b100,
    BIU_INSTR_WORD_FETCH = 3'b101,
    BIU_DATA_WORD_ACCESS = 3'b110
  } biu_e;

  typedef struct packed {
    logic orEn;
    logic altEn;
    alt_mode_e altMode;
    logic [NUM_DET-1:0] orMask;
    logic [NUM_DET-1:0] andMask;
    logic [NUM_EXC-1:0] excMask;
    logic [DELAY_W-1:0] delay;
    logic [ADDR_W-1:0] rangeLo;
    logic [ADDR_W-1:0] rangeHi;
    logic [EVT_W-1:0] subrEvt;
    logic [SEQ_STEPS-1:0][EVT_W-1:0] seqEvt;
    logic [2:0] seqLen;
    logic [EVT_W:0] seqRst;
    logic [EVT_W:0] tsRst;
    logic [TS_PATHS-1:0][PATH_W-1:0] tsPath;
    logic [NUM_DET-1:0][ADDR_W-1:0] detAddr;
    logic [NUM_DET-1:0][ADDR_W-1:0] detMask;
    logic [NUM_DET-1:0][DET_CTRL_W-1:0] detCtrl;
  } cfg_s;

endpackage

// ==== event_detector.sv ====
`timescale 1ns/10ps
module event_detector
  import hw_break_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [hw_break_pkg::ADDR_W-1:0] cfgAddr,
  input wire logic [hw_break_pkg::ADDR_W-1:0] cfgMask,
  input wire logic [hw_break_pkg::DET_CTRL_W-1:0] cfgCtrl,
  input wire logic [hw_break_pkg::ADDR_W-1:0] busAddr,
  input wire logic [2:0] busState,
  input wire logic busWrite,
  input wire logic busValid,
  output logic hit
);
  import hw_break_pkg::*;

  typedef struct packed {
    logic hit;
  } det_s;

  det_s s;
  det_s next_s;
  logic addrOk;
  logic rwOk;
  logic stateOk;

  always_comb begin
    addrOk = ((busAddr ^ cfgAddr) & cfgMask) == '0;
    case (cfgCtrl[DCTL_RW_LSB +: 2])
      RW_READ: rwOk = !busWrite;
      RW_WRITE: rwOk = busWrite;
      default: rwOk = 1'b1;
    endcase
    stateOk = cfgCtrl[DCTL_ANY_BIT] || (busState == cfgCtrl[DCTL_STATE_LSB +: 3]);
    next_s.hit = cfgCtrl[DCTL_EN_BIT] && busValid && addrOk && rwOk && stateOk;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hit = s.hit;

endmodule

// ==== hw_break_asserts.sv ====
`timescale 1ns/10ps
module hw_break_checker
  import hw_break_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic progRunning,
  input wire logic haltReq,
  input wire logic breakArmed
);
  import hw_break_pkg::*;
  // ****************************************************************
  // Halt and rearm
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_HALT_PULSE: assert property (haltReq |=> !haltReq)
    else $error("halt request held past one cycle");
  AST_HALT_DISARMS: assert property (haltReq |-> !breakArmed)
    else $error("still armed while halting");
  AST_HALT_NEEDS_ARM: assert property (haltReq |-> $past(breakArmed))
    else $error("halt while disarmed");
  AST_DISARMED_QUIET: assert property (!breakArmed |=> !haltReq)
    else $error("second halt without rearm");
  AST_APPLY_REARMS: assert property (regWrite && regAddr == REG_APPLY && !breakArmed |=> breakArmed)
    else $error("apply did not rearm");
  AST_RUN_REARMS: assert property ($rose(progRunning) && !breakArmed |=> breakArmed)
    else $error("program start did not rearm");
  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside its cycle");
  AST_STATUS_ARMED: assert property (regRead && regAddr == REG_STATUS |=>
    regRdata[ST_ARMED_BIT] == $past(breakArmed))
    else $error("status armed bit wrong");
endmodule

bind hw_break_and_trace_unit hw_break_checker chk_i (.clock(clock), .rst(rst),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .progRunning(progRunning), .haltReq(haltReq), .breakArmed(breakArmed));

// ==== target_bus_model.sv ====
`timescale 1ns/10ps
module target_bus_model
  import hw_break_pkg::*;
(
  input wire logic clock,
  input wire logic haltReq,
  output logic [hw_break_pkg::ADDR_W-1:0] busAddr,
  output logic [hw_break_pkg::DATA_W-1:0] busData,
  output logic [2:0] busState,
  output logic busWrite,
  output logic busValid,
  output logic progRunning,
  output logic [hw_break_pkg::NUM_EXC-1:0] excEvent
);
  import hw_break_pkg::*;
  initial {busAddr, busData, busState, busWrite, busValid, progRunning, excEvent} = '0;
  // Target stops one cycle after the request
  always @(posedge clock) if (haltReq === 1'b1) progRunning <= 1'b0;
  task automatic run();
    @(posedge clock);
    progRunning <= 1'b1;
  endtask
  // Released bus shows inverted address and data, never the last ones; state goes idle
  task automatic cyc(input logic [23:0] a, input logic [15:0] d, input logic [2:0] s,
      output time t);
    @(posedge clock);
    t = $time;
    {busAddr, busData, busState, busWrite, busValid} <= {a, d, s, d[0], 1'b1};
    @(posedge clock);
    {busAddr, busData, busState, busWrite, busValid} <= {~a, ~d, BIU_IDLE, 2'b00};
  endtask
  task automatic exc(input logic [6:0] e, output time t);
    @(posedge clock);
    t = $time;
    excEvent <= e;
    @(posedge clock);
    excEvent <= '0;
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  import hw_break_pkg::*;
  logic clock, rst, regWrite, regRead, rdWas, busWrite, busValid, progRunning;
  logic haltReq, breakArmed;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, dly;
  logic [ADDR_W-1:0] busAddr;
  logic [DATA_W-1:0] busData, dat, d3;
  logic [2:0] busState;
  logic [NUM_EXC-1:0] excEvent;
  logic [31:0] rq[$];
  time hq[$], sq[$], t, e;
  int num_errors = 0, total_checks = 0, i, seed = 32'h85b8;
  int ks[6] = '{3, 2, 4, 3, 2, 3};
  hw_break_and_trace_unit dut (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .busAddr(busAddr), .busData(busData), .busState(busState), .busWrite(busWrite),
    .busValid(busValid), .progRunning(progRunning), .excEvent(excEvent),
    .haltReq(haltReq), .breakArmed(breakArmed));
  target_bus_model tgt (.clock(clock), .haltReq(haltReq), .busAddr(busAddr),
    .busData(busData), .busState(busState), .busWrite(busWrite), .busValid(busValid),
    .progRunning(progRunning), .excEvent(excEvent));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [23:0] adr(input int k);
    return 24'h001000 + 24'(k * 16);
  endfunction
  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    {regAddr, regRead} <= {a, 1'b1};
    rq.push_back(x);
    @(posedge clock);
    regRead <= 1'b0;
  endtask
  // Bounded wait for the noted halts to be seen
  task automatic waitq(input int n);
    for (int k = 0; k < n + 20 && hq.size() > 0; k++) @(posedge clock);
    if (hq.size() > 0) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic hit(input int k, input int n, input logic yes);
    dat = 16'($random(seed));
    tgt.cyc(adr(k), dat, 3'(k % 7), t);
    if (yes) begin
      hq.push_back(t + (3 + n) * 40);
      sq.push_back(0);
      waitq(n);
    end else repeat (8) @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (rdWas === 1'b1) chk(regRdata, rq.pop_front());
    rdWas <= regRead;
    if (haltReq === 1'b1 && hq.size() == 0) chk(haltReq, 1'b0);
    else if (haltReq === 1'b1) begin
      e = hq.pop_front();
      chk($time, ($time >= e && $time <= e + sq.pop_front()) ? $time : e);
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {rst, regAddr, regWdata, regWrite, regRead, rdWas} = {1'b1, 43'h0};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(REG_CTRL, 32'h1);
    rd(REG_STATUS, 32'h1);
    rd(REG_DELAY, 32'h0);
    rd(8'h12, 32'h0);
    for (i = 0; i < NUM_DET; i++) begin
      wr(8'(REG_DET_BASE + 2 * i), 32'h0900_0000 | adr(i));
      wr(8'(REG_DET_BASE + 2 * i + 1), 32'h00ff_ffff);
    end
    wr(REG_OR_MASK, 32'hffff);
    wr(REG_APPLY, 32'h0);
    tgt.run();
    for (i = 0; i < NUM_DET; i++) begin
      hit(i, 0, 1'b1);
      tgt.run();
    end
    dly = $random(seed) & 32'h1f;
    wr(REG_DELAY, dly);
    wr(REG_APPLY, 32'h0);
    rd(REG_DELAY, dly);
    hit(3, dly, 1'b1);
    d3 = dat;
    hit(4, 0, 1'b0);
    wr(REG_TRACE_IDX, 32'h0);
    repeat (2) @(posedge clock);
    rd(REG_TRACE_REC, {8'h0, ~adr(3)});
    rd(REG_TRACE_DATA, {16'h0, ~d3});
    rd(REG_STOP_NUM, dly + 32'h1);
    tgt.run();
    wr(REG_OR_MASK, 32'h0);
    wr(REG_DELAY, 32'h0);
    for (i = 0; i < NUM_EXC; i++) begin
      wr(REG_EXC_MASK, 32'h1 << i);
      wr(REG_APPLY, 32'h0);
      tgt.exc(7'h1 << ((i + 1) % 7), t);
      repeat (6) @(posedge clock);
      tgt.exc(7'h1 << i, t);
      hq.push_back(t + 80);
      sq.push_back(0);
      waitq(0);
      tgt.run();
    end
    wr(REG_EXC_MASK, 32'h0);
    wr(REG_OR_MASK, 32'h20);
    wr(REG_AND_MASK, 32'h3);
    wr(REG_CTRL, 32'h3);
    wr(REG_APPLY, 32'h0);
    hit(0, 0, 1'b0);
    hit(1, 0, 1'b1);
    wr(REG_APPLY, 32'h0);
    tgt.run();
    hit(5, 0, 1'b1);
    tgt.run();
    wr(8'(REG_DET_BASE + 31), 32'h0);
    wr(REG_AND_MASK, 32'h8001);
    wr(REG_CTRL, 32'h6);
    wr(REG_APPLY, 32'h0);
    hit(1, 0, 1'b0);
    hit(0, 0, 1'b1);
    wr(REG_SEQ, 32'h0200_0032);
    wr(REG_SEQ_RST, 32'h14);
    wr(REG_TS_RST, 32'h14);
    wr(REG_PATH_BASE, 32'h112);
    wr(8'(REG_PATH_BASE + 1), 32'h173);
    // Same event order drives the sequencer, then the three-state machine
    for (i = 0; i < 2; i++) begin
      wr(REG_CTRL, i ? 32'h12 : 32'he);
      wr(REG_APPLY, 32'h0);
      tgt.run();
      foreach (ks[j]) begin
        // Slow round trips in state mode, to show the state is held with no timeout
        repeat (i * 250) @(posedge clock);
        hit(ks[j], 0, j == 5);
      end
    end
    wr(REG_RANGE_LO, 32'(adr(5)));
    wr(REG_RANGE_HI, 32'(adr(5)));
    wr(REG_SUBR_EVT, 32'h4);
    wr(REG_CTRL, 32'ha);
    wr(REG_APPLY, 32'h0);
    tgt.run();
    hit(4, 0, 1'b0);
    hit(5, 0, 1'b0);
    hit(4, 0, 1'b1);
    repeat (5) @(posedge clock);
    if (hq.size() != 0 || rq.size() != 0) num_errors++;
    conclude();
  end
endmodule
